// ### bench/mead_dram_seq_model.sv
// Refresh sequencer model that completes the register bank's refresh requests
`timescale 1ns/10ps
`default_nettype none

module mead_dram_seq_model (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic refresh_req,
	input  wire logic stall,
	output logic      refresh_done
);
	// One completion pulse per pending request, held back while stalled
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			refresh_done <= 1'b0;
		end else begin
			refresh_done <= refresh_req && !stall && !refresh_done;
		end
	end
endmodule
`default_nettype wire

// ### bench/mead_regs_test.sv
// Self-checking testbench for the memory error and decode register bank
`timescale 1ns/10ps
`default_nettype none

module mead_regs_test;
	import mead_pkg::*;

	logic              ref_clk;
	logic              rst;
	mead_reg_req_type  reg_req;
	logic [31:0]       reg_rdata;
	logic              reg_rvalid;
	mead_err_type      read_err;
	mead_err_type      self_test_err;
	logic              data_error_clear;
	mead_cap_type      data_error_held;
	mead_bs_err_type   bs_err;
	logic              hold_need;
	logic              hold;
	logic              refresh_req;
	logic              refresh_done;
	logic              stall;
	logic [1:0]        arb_sel;
	logic [31:0]       test_ctl;
	logic [BUS_AW-1:0] bus_addr;
	logic              addr_hit;
	int                errors;
	int                n_tests;
	logic [2:0]        n_rates [2] = '{3'd0, 3'd3};

	mead_regs #(.REF_STEP_CYC(4)) u_dut (
		.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .read_err(read_err), .self_test_err(self_test_err),
		.data_error_clear(data_error_clear), .data_error_held(data_error_held),
		.bs_err(bs_err), .read_response_hold_need(hold_need), .read_response_hold(hold),
		.refresh_req(refresh_req), .refresh_done(refresh_done),
		.arbitration_suppress_select(arb_sel), .manufacturing_test_control(test_ctl),
		.bus_addr(bus_addr), .addr_hit(addr_hit)
	);

	mead_dram_seq_model u_seq (
		.ref_clk(ref_clk), .rst(rst), .refresh_req(refresh_req), .stall(stall),
		.refresh_done(refresh_done)
	);

	// Free-running clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ****************
	// Shared tasks
	// ****************
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge ref_clk);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge ref_clk);
		reg_req = '0;
	endtask

	// Read answer stands one cycle after the request edge
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		@(negedge ref_clk);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(negedge ref_clk);
		reg_req = '0;
		check({31'h0, reg_rvalid}, 32'h1);
		check(reg_rdata, exp);
	endtask

	task automatic err_ev(input logic st, input logic unc, input logic [31:0] a);
		@(negedge ref_clk);
		if (st) begin
			self_test_err = '{valid: 1'b1, uncorr: unc, addr: a};
		end else begin
			read_err = '{valid: 1'b1, uncorr: unc, addr: a};
		end
		@(negedge ref_clk);
		read_err = '0;
		self_test_err = '0;
	endtask

	task automatic wait_req(input logic lvl);
		int i;
		for (i = 0; i < 100 && refresh_req !== lvl; i++) begin
			@(negedge ref_clk);
		end
		if (refresh_req !== lvl) begin
			errors++;
			$display("Error at %0t: refresh request got %h expected %h", $time, refresh_req, lvl);
			stop_test();
		end
	endtask

	task automatic count_rises(input int cyc, output int n);
		logic prev;
		prev = refresh_req;
		n = 0;
		repeat (cyc) begin
			@(negedge ref_clk);
			if (refresh_req === 1'b1 && prev !== 1'b1) begin
				n++;
			end
			prev = refresh_req;
		end
	endtask

	task automatic probe(input logic [4:0] s, input logic [9:0] b, input logic [8:0] lo,
			input logic exp);
		@(negedge ref_clk);
		bus_addr = {s, b, 15'h0, lo};
		@(negedge ref_clk);
		check({31'h0, addr_hit}, {31'h0, exp});
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		logic [7:0] ofs [8] = '{OFS_DERR_ADDR, OFS_REF_CTL, OFS_TEST_CTL, OFS_BS_STATUS,
			OFS_BS_ADDR, OFS_START, OFS_END, OFS_SEG_ILV};
		foreach (ofs[i]) begin
			reg_rd(ofs[i], REG_RST);
		end
		check({30'h0, data_error_held}, {30'h0, CAP_EMPTY});
		$display("Test reset values done");
	endtask

	task automatic t_fields();
		reg_wr(OFS_START, 32'hffff_ffff);
		reg_rd(OFS_START, 32'h0000_ffc0);
		reg_wr(OFS_END, 32'hffff_ffff);
		reg_rd(OFS_END, 32'h0001_ffc0);
		reg_wr(OFS_SEG_ILV, 32'hffff_ffff);
		reg_rd(OFS_SEG_ILV, 32'h001f_00e3);
		reg_wr(OFS_DERR_ADDR, 32'hffff_ffff);
		reg_rd(OFS_DERR_ADDR, 32'h0);
		reg_wr(OFS_TEST_CTL, 32'ha5c3_0f96);
		reg_rd(OFS_TEST_CTL, 32'ha5c3_0f96);
		check(test_ctl, 32'ha5c3_0f96);
		reg_rd(8'h40, 32'h0);
		$display("Test field access done");
	endtask

	task automatic t_capture();
		err_ev(1'b0, 1'b0, 32'h1234_567f);
		reg_rd(OFS_DERR_ADDR, 32'h1234_5678);
		check({30'h0, data_error_held}, {30'h0, CAP_CORR});
		err_ev(1'b0, 1'b0, 32'h2222_2220);
		reg_rd(OFS_DERR_ADDR, 32'h1234_5678);
		err_ev(1'b0, 1'b1, 32'h3333_3338);
		reg_rd(OFS_DERR_ADDR, 32'h3333_3338);
		err_ev(1'b0, 1'b1, 32'h4444_4440);
		reg_rd(OFS_DERR_ADDR, 32'h3333_3338);
		err_ev(1'b0, 1'b0, 32'h5555_5550);
		reg_rd(OFS_DERR_ADDR, 32'h3333_3338);
		@(negedge ref_clk);
		data_error_clear = 1'b1;
		@(negedge ref_clk);
		data_error_clear = 1'b0;
		err_ev(1'b1, 1'b1, 32'h6666_6668);
		reg_rd(OFS_DERR_ADDR, 32'h6666_6668);
		check({30'h0, data_error_held}, {30'h0, CAP_UNCORR});
		$display("Test error capture done");
	endtask

	task automatic t_block();
		@(negedge ref_clk);
		bs_err = '{valid: 1'b1, kind: 3'b111, addr: 32'h0abc_de00};
		@(negedge ref_clk);
		bs_err = '0;
		reg_rd(OFS_BS_STATUS, 32'ha100_0000);
		reg_rd(OFS_BS_ADDR, 32'h0abc_de00);
		@(negedge ref_clk);
		bs_err = '{valid: 1'b1, kind: 3'b111, addr: 32'h1111_1100};
		@(negedge ref_clk);
		bs_err = '0;
		reg_rd(OFS_BS_ADDR, 32'h0abc_de00);
		reg_wr(OFS_BS_STATUS, 32'ha100_0000);
		reg_rd(OFS_BS_STATUS, 32'h0);
		$display("Test block state log done");
	endtask

	task automatic t_refresh();
		int n;
		foreach (n_rates[i]) begin
			reg_wr(OFS_REF_CTL, {27'h0, n_rates[i], 2'b00});
			count_rises(40 * (n_rates[i] + 1), n);
			check({31'h0, n >= 9 && n <= 11}, 32'h1);
		end
		reg_wr(OFS_REF_CTL, 32'h0000_001c);
		wait_req(1'b1);
		wait_req(1'b0);
		reg_wr(OFS_REF_CTL, 32'h0002_001c);
		check({31'h0, refresh_req}, 32'h1);
		count_rises(8, n);
		check(n, 32'h0);
		check({31'h0, refresh_req}, 32'h0);
		stall = 1'b1;
		reg_wr(OFS_REF_CTL, 32'h0002_001c);
		reg_wr(OFS_REF_CTL, 32'h0002_001c);
		reg_rd(OFS_REF_CTL, 32'h0001_001c);
		stall = 1'b0;
		wait_req(1'b0);
		reg_wr(OFS_REF_CTL, 32'h0001_001e);
		reg_rd(OFS_REF_CTL, 32'h0000_001e);
		check({30'h0, arb_sel}, 32'h2);
		hold_need = 1'b1;
		repeat (2) @(negedge ref_clk);
		reg_rd(OFS_REF_CTL, 32'h0000_003e);
		check({31'h0, hold}, 32'h1);
		hold_need = 1'b0;
		$display("Test refresh control done");
	endtask

	task automatic t_decode();
		reg_wr(OFS_START, 32'h0000_0a00);
		reg_wr(OFS_END, 32'h0000_0c80);
		reg_wr(OFS_SEG_ILV, 32'h0003_00a0);
		probe(5'd3, 10'd40, 9'h0, 1'b1);
		probe(5'd3, 10'd50, 9'h0, 1'b1);
		probe(5'd3, 10'd39, 9'h0, 1'b0);
		probe(5'd3, 10'd51, 9'h0, 1'b0);
		probe(5'd2, 10'd45, 9'h0, 1'b0);
		reg_wr(OFS_SEG_ILV, 32'h0003_00a1);
		probe(5'd3, 10'd45, 9'h040, 1'b1);
		probe(5'd3, 10'd45, 9'h000, 1'b0);
		reg_wr(OFS_SEG_ILV, 32'h0003_00a2);
		probe(5'd3, 10'd45, 9'h040, 1'b1);
		probe(5'd3, 10'd45, 9'h080, 1'b0);
		reg_wr(OFS_SEG_ILV, 32'h0003_00a3);
		probe(5'd3, 10'd45, 9'h140, 1'b1);
		probe(5'd3, 10'd45, 9'h100, 1'b0);
		reg_wr(OFS_SEG_ILV, 32'h0003_00a0);
		reg_wr(OFS_END, 32'h0001_0c80);
		probe(5'd3, 10'd1023, 9'h0, 1'b1);
		probe(5'd3, 10'd39, 9'h0, 1'b0);
		$display("Test address decode done");
	endtask

	// Main sequence
	initial begin
		errors = 0;
		n_tests = 0;
		rst = 1'b1;
		reg_req = '0;
		read_err = '0;
		self_test_err = '0;
		data_error_clear = 1'b0;
		bs_err = '0;
		hold_need = 1'b0;
		stall = 1'b0;
		bus_addr = '0;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		t_reset();
		t_fields();
		t_capture();
		t_block();
		t_refresh();
		t_decode();
		stop_test();
	end
endmodule
`default_nettype wire

// ### hw/mead_err_capture.sv
// Error address capture with uncorrectable-over-corrected priority
`timescale 1ns/10ps
`default_nettype none

module mead_err_capture (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire mead_pkg::mead_err_type err,
	input  wire logic                   clear,
	output logic [31:0]                 addr,
	output mead_pkg::mead_cap_type      held
);
	import mead_pkg::*;

	mead_cap_state_type s_q;
	mead_cap_state_type s_d;
	mead_cap_type       base;

	// ********************************
	// Capture decision
	// ********************************

	// A clear and a new error in one cycle keep the new error
	always_comb begin
		s_d  = s_q;
		base = clear ? CAP_EMPTY : s_q.held;
		s_d.held = base;
		if (err.valid && err.uncorr && base != CAP_UNCORR) begin
			s_d.held = CAP_UNCORR;
			s_d.addr = {err.addr[31:ERRADR_LSB], 3'h0};
		end else if (err.valid && !err.uncorr && base == CAP_EMPTY) begin
			s_d.held = CAP_CORR;
			s_d.addr = {err.addr[31:ERRADR_LSB], 3'h0};
		end
	end

	// State register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q <= '{held: CAP_EMPTY, addr: REG_RST};
		end else begin
			s_q <= s_d;
		end
	end

	assign addr = s_q.addr;
	assign held = s_q.held;

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_first_corr_kept: assert property (
		s_q.held == CAP_CORR && !clear && !(err.valid && err.uncorr) |=> $stable(s_q.addr))
		else $error("corrected address changed while held");
	chk_uncorr_replaces: assert property (
		s_q.held == CAP_CORR && !clear && err.valid && err.uncorr
		|=> s_q.held == CAP_UNCORR && s_q.addr[31:3] == $past(err.addr[31:3]))
		else $error("uncorrectable error did not replace corrected address");
	chk_uncorr_locked: assert property (
		s_q.held == CAP_UNCORR && !clear |=> s_q.held == CAP_UNCORR && $stable(s_q.addr))
		else $error("held uncorrectable address was overwritten");
	chk_low_bits_zero: assert property (
		s_q.addr[2:0] == 3'h0)
		else $error("captured address low bits not zero");
	cov_corr_then_uncorr: cover property (
		s_q.held == CAP_CORR ##1 s_q.held == CAP_UNCORR);

endmodule

`default_nettype wire

// ### hw/mead_pkg.sv
// Package of offsets, fields, timing and carrier types for the memory error and decode registers
package mead_pkg;

	// ********************************
	// Address geometry
	// ********************************
	localparam int unsigned BUS_AW      = 39;  // Five segment bits above a 16-Gbyte segment
	localparam int unsigned SEG_BUS_LSB = 34;  // Lowest bus address bit of the segment number
	localparam int unsigned BLK_LSB     = 24;  // Start and end granule is 16 Mbytes
	localparam int unsigned ILV_LSB     = 6;   // Interleave unit is 64 bytes
	localparam int unsigned OFS_W       = 8;

	// ********************************
	// Register offsets in node space
	// ********************************
	localparam logic [7:0] OFS_DERR_ADDR = 8'h1c;
	localparam logic [7:0] OFS_REF_CTL   = 8'h30;
	localparam logic [7:0] OFS_TEST_CTL  = 8'h34;
	localparam logic [7:0] OFS_BS_STATUS = 8'h38;
	localparam logic [7:0] OFS_BS_ADDR   = 8'h3c;
	localparam logic [7:0] OFS_START     = 8'h50;
	localparam logic [7:0] OFS_END       = 8'h54;
	localparam logic [7:0] OFS_SEG_ILV   = 8'h58;

	// ********************************
	// Field positions and reset values
	// ********************************
	localparam int unsigned ERRADR_LSB   = 3;
	localparam int unsigned FORCE_BIT    = 17;
	localparam int unsigned MISS_BIT     = 16;
	localparam int unsigned HOLD_BIT     = 5;
	localparam int unsigned RATE_LSB     = 2;
	localparam int unsigned ARB_LSB      = 0;
	localparam int unsigned BS_FLAG_HI   = 31;
	localparam int unsigned BS_FLAG_MID  = 29;
	localparam int unsigned BS_FLAG_LO   = 24;
	localparam int unsigned ADDR_FLD_LSB = 6;
	localparam int unsigned TOP_SEG_BIT  = 16;
	localparam int unsigned SEG_LSB      = 16;
	localparam int unsigned INTERLEAVE_SELECT_FIELD_LSB     = 5;
	localparam int unsigned INTERLEAVE_FACTOR_FIELD_LSB     = 0;
	localparam logic [31:0] REG_RST      = 32'h0000_0000;

	// ********************************
	// Timing
	// ********************************
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned REF_UNIT_NS   = 1000;  // Refresh interval step per rate code
	localparam int unsigned REF_UNIT_CYC  = REF_UNIT_NS * 1000 / CLK_PERIOD_PS;

	// ********************************
	// Types
	// ********************************
	typedef enum logic [1:0] {ILV_NONE, ILV_2WAY, ILV_4WAY, ILV_8WAY} mead_ilv_type;
	typedef enum logic [1:0] {CAP_EMPTY, CAP_CORR, CAP_UNCORR} mead_cap_type;

	typedef struct packed {
		logic             wr;
		logic             rd;
		logic [OFS_W-1:0] addr;
		logic [31:0]      wdata;
	} mead_reg_req_type;

	typedef struct packed {
		logic        valid;
		logic        uncorr;
		logic [31:0] addr;
	} mead_err_type;

	typedef struct packed {
		logic        valid;
		logic [2:0]  kind;
		logic [31:0] addr;
	} mead_bs_err_type;

	typedef struct packed {
		mead_cap_type held;
		logic [31:0]  addr;
	} mead_cap_state_type;

	typedef struct packed {
		logic [11:0]  ref_cnt;
		logic         pending;
		logic         miss;
		logic [2:0]   rate;
		logic [1:0]   arb;
		logic         hold;
		logic [31:0]  test;
		logic [2:0]   bs_flags;
		logic [9:0]   start;
		logic [9:0]   end_addr;
		logic         top;
		logic [4:0]   seg;
		logic [2:0]   interleave_select_field;
		mead_ilv_type interleave_factor_field;
		logic [31:0]  rdata;
		logic         rvalid;
		logic         hit;
	} mead_state_type;

endpackage

// ### hw/mead_regs.sv
// Memory error address, refresh control and address decode register bank
`timescale 1ns/10ps
`default_nettype none

// Function
// - Hold address of first corrected read error
// - Uncorrectable error replaces held corrected address
// - Corrected error never replaces uncorrectable address
// - Only first uncorrectable address is kept
// - Error address bits 31:3, low bits zero
// - Capture self-test errors as well, except in a cycle that also has a read error
// - Force bit starts one refresh of all
// - Missed refresh sets flag, write one clears
// - Read-only hold mode bit for responses
// - Rate field sets refresh interval
// - Arbitration suppression select field, reset zero
// - Log block-state errors in self-test, normal
// - Starting address in bits 15:6 only
// - Ending address in bits 15:6
// - Top bit extends end to segment top
// - Range from start, end, segment, interleave
// - Segment field matches upper bus address
// - Interleave select field in bits 7:5
// - Interleave factor field steers address match
// - Memory may sit above 512 Mbytes
module mead_regs #(
	parameter int unsigned REF_STEP_CYC = mead_pkg::REF_UNIT_CYC
) (
	input  wire logic                              ref_clk,
	input  wire logic                              rst,
	input  wire mead_pkg::mead_reg_req_type        reg_req,
	output logic [31:0]                            reg_rdata,
	output logic                                   reg_rvalid,
	input  wire mead_pkg::mead_err_type            read_err,
	input  wire mead_pkg::mead_err_type            self_test_err,
	input  wire logic                              data_error_clear,
	output mead_pkg::mead_cap_type                 data_error_held,
	input  wire mead_pkg::mead_bs_err_type         bs_err,
	input  wire logic                              read_response_hold_need,
	output logic                                   read_response_hold,
	output logic                                   refresh_req,
	input  wire logic                              refresh_done,
	output logic [1:0]                             arbitration_suppress_select,
	output logic [31:0]                            manufacturing_test_control,
	input  wire logic [mead_pkg::BUS_AW-1:0]       bus_addr,
	output logic                                   addr_hit
);
	import mead_pkg::*;

	// Elaboration check: the 12-bit timer must hold eight rate steps
	if (REF_STEP_CYC < 1 || REF_STEP_CYC * 8 > 4095) begin : g_bad_step
		$error("REF_STEP_CYC out of range for a 12-bit refresh timer");
	end

	mead_state_type     s_q;
	mead_state_type     s_d;
	mead_err_type       data_err;
	mead_err_type       bs_cap_err;
	logic               bs_clear;
	logic [31:0]        derr_addr;
	logic [31:0]        bs_addr;
	mead_cap_type       bs_held;
	logic               wr_ref;
	logic               wr_bs;
	logic               force_ev;
	logic               tick;
	logic               ref_ev;
	logic               miss_ev;
	logic [2:0]         bs_w1c;
	logic [2:0]         bs_ev;
	logic [11:0]        reload;
	logic [9:0]         blk;
	logic               seg_ok;
	logic               range_ok;
	logic               ilv_ok;

	// ********************************
	// Error address capture
	// ********************************

	// Read errors take the port first; self-test errors use it when reads are quiet
	assign data_err = read_err.valid ? read_err : self_test_err;

	mead_err_capture u_data_cap (
		.ref_clk (ref_clk),
		.rst     (rst),
		.err     (data_err),
		.clear   (data_error_clear),
		.addr    (derr_addr),
		.held    (data_error_held)
	);

	// Block-state errors from self-test or normal traffic; first one is kept
	assign bs_cap_err = '{valid: bs_err.valid, uncorr: 1'b1, addr: bs_err.addr};
	assign bs_clear   = wr_bs && ((s_q.bs_flags & ~bs_w1c) == 3'h0);

	mead_err_capture u_bs_cap (
		.ref_clk (ref_clk),
		.rst     (rst),
		.err     (bs_cap_err),
		.clear   (bs_clear),
		.addr    (bs_addr),
		.held    (bs_held)
	);

	// ********************************
	// Write decode and refresh events
	// ********************************

	// Strobes for registers with side effects
	assign wr_ref   = reg_req.wr && reg_req.addr == OFS_REF_CTL;
	assign wr_bs    = reg_req.wr && reg_req.addr == OFS_BS_STATUS;
	assign force_ev = wr_ref && reg_req.wdata[FORCE_BIT];
	assign bs_w1c   = wr_bs ? {reg_req.wdata[BS_FLAG_HI], reg_req.wdata[BS_FLAG_MID],
		reg_req.wdata[BS_FLAG_LO]} : 3'h0;
	assign bs_ev    = bs_err.valid ? bs_err.kind : 3'h0;

	// Interval timer reload: one step per rate code plus one
	assign reload  = 12'((32'(s_q.rate) + 32'd1) * REF_STEP_CYC - 32'd1);
	assign tick    = s_q.ref_cnt == 12'h000;
	assign ref_ev  = tick || force_ev;
	assign miss_ev = ref_ev && s_q.pending && !refresh_done;

	// ********************************
	// Address decode
	// ********************************

	// Granule of the bus address within its segment
	assign blk      = bus_addr[BLK_LSB +: 10];
	assign seg_ok   = bus_addr[SEG_BUS_LSB +: 5] == s_q.seg;
	assign range_ok = blk >= s_q.start && (s_q.top || blk <= s_q.end_addr);

	// Interleave match on the low line-address bits
	always_comb begin
		unique case (s_q.interleave_factor_field)
			ILV_NONE: ilv_ok = 1'b1;
			ILV_2WAY: ilv_ok = bus_addr[ILV_LSB] == s_q.interleave_select_field[0];
			ILV_4WAY: ilv_ok = bus_addr[ILV_LSB +: 2] == s_q.interleave_select_field[1:0];
			ILV_8WAY: ilv_ok = bus_addr[ILV_LSB +: 3] == s_q.interleave_select_field;
		endcase
	end

	// ********************************
	// Next state
	// ********************************

	// All register state moves here; reads answer one cycle after the strobe
	always_comb begin
		s_d        = s_q;
		s_d.rvalid = reg_req.rd;
		s_d.hit    = seg_ok && range_ok && ilv_ok;
		s_d.hold   = read_response_hold_need;

		// Refresh timer and pending request
		s_d.ref_cnt = tick ? reload : s_q.ref_cnt - 12'h001;
		s_d.pending = (s_q.pending && !refresh_done) || ref_ev;
		s_d.miss    = (s_q.miss && !(wr_ref && reg_req.wdata[MISS_BIT])) || miss_ev;

		// Block-state flags: a new error wins over its clear
		s_d.bs_flags = (s_q.bs_flags & ~bs_w1c) | bs_ev;

		// Plain register writes
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				OFS_REF_CTL: begin
					s_d.rate = reg_req.wdata[RATE_LSB +: 3];
					s_d.arb  = reg_req.wdata[ARB_LSB +: 2];
				end
				OFS_TEST_CTL: begin
					s_d.test = reg_req.wdata;
				end
				OFS_START: begin
					s_d.start = reg_req.wdata[ADDR_FLD_LSB +: 10];
				end
				OFS_END: begin
					s_d.end_addr = reg_req.wdata[ADDR_FLD_LSB +: 10];
					s_d.top      = reg_req.wdata[TOP_SEG_BIT];
				end
				OFS_SEG_ILV: begin
					s_d.seg  = reg_req.wdata[SEG_LSB +: 5];
					s_d.interleave_select_field = reg_req.wdata[INTERLEAVE_SELECT_FIELD_LSB +: 3];
					s_d.interleave_factor_field = mead_ilv_type'(reg_req.wdata[INTERLEAVE_FACTOR_FIELD_LSB +: 2]);
				end
				default: begin
				end
			endcase
		end

		// Read data; unmapped offsets and reserved bits read zero
		s_d.rdata = REG_RST;
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				OFS_DERR_ADDR: s_d.rdata = derr_addr;
				OFS_REF_CTL: begin
					s_d.rdata[MISS_BIT]         = s_q.miss;
					s_d.rdata[HOLD_BIT]         = s_q.hold;
					s_d.rdata[RATE_LSB +: 3]    = s_q.rate;
					s_d.rdata[ARB_LSB +: 2]     = s_q.arb;
				end
				OFS_TEST_CTL: s_d.rdata = s_q.test;
				OFS_BS_STATUS: begin
					s_d.rdata[BS_FLAG_HI]  = s_q.bs_flags[2];
					s_d.rdata[BS_FLAG_MID] = s_q.bs_flags[1];
					s_d.rdata[BS_FLAG_LO]  = s_q.bs_flags[0];
				end
				OFS_BS_ADDR: s_d.rdata = bs_addr;
				OFS_START: s_d.rdata[ADDR_FLD_LSB +: 10] = s_q.start;
				OFS_END: begin
					s_d.rdata[ADDR_FLD_LSB +: 10] = s_q.end_addr;
					s_d.rdata[TOP_SEG_BIT]        = s_q.top;
				end
				OFS_SEG_ILV: begin
					s_d.rdata[SEG_LSB +: 5]  = s_q.seg;
					s_d.rdata[INTERLEAVE_SELECT_FIELD_LSB +: 3] = s_q.interleave_select_field;
					s_d.rdata[INTERLEAVE_FACTOR_FIELD_LSB +: 2] = s_q.interleave_factor_field;
				end
				default: s_d.rdata = REG_RST;
			endcase
		end
	end

	// ********************************
	// State register
	// ********************************

	// First timer tick comes one rate-zero interval after reset
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q <= '{
				ref_cnt:  12'(REF_STEP_CYC - 1),
				pending:  1'b0,
				miss:     1'b0,
				rate:     3'h0,
				arb:      2'h0,
				hold:     1'b0,
				test:     REG_RST,
				bs_flags: 3'h0,
				start:    10'h000,
				end_addr: 10'h000,
				top:      1'b0,
				seg:      5'h00,
				interleave_select_field:     3'h0,
				interleave_factor_field:     ILV_NONE,
				rdata:    REG_RST,
				rvalid:   1'b0,
				hit:      1'b0
			};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata                   = s_q.rdata;
	assign reg_rvalid                  = s_q.rvalid;
	assign read_response_hold          = s_q.hold;
	assign refresh_req                 = s_q.pending;
	assign arbitration_suppress_select = s_q.arb;
	assign manufacturing_test_control  = s_q.test;
	assign addr_hit                    = s_q.hit;

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_force_refresh_req: assert property (
		force_ev |=> refresh_req)
		else $error("forced refresh not requested");
	chk_missed_refresh: assert property (
		s_q.pending && !refresh_done && force_ev |=> s_q.miss ##1 s_q.miss || $past(wr_ref))
		else $error("missed refresh not flagged");
	chk_hold_mirror: assert property (
		1'b1 |=> read_response_hold == $past(read_response_hold_need))
		else $error("hold mode bit does not follow its source");
	chk_refresh_reload: assert property (
		tick |=> 32'(s_q.ref_cnt) == (32'($past(s_q.rate)) + 1) * REF_STEP_CYC - 1)
		else $error("refresh interval reload wrong");
	chk_arb_select: assert property (
		wr_ref |=> arbitration_suppress_select == $past(reg_req.wdata[1:0]))
		else $error("arbitration select not written");
	chk_start_readback: assert property (
		reg_req.rd && reg_req.addr == OFS_START
		|=> reg_rvalid && reg_rdata[31:16] == 16'h0000 && reg_rdata[5:0] == 6'h00)
		else $error("starting address reserved bits not zero");
	chk_top_segment_hit: assert property (
		s_q.top && seg_ok && ilv_ok && blk >= s_q.start |=> addr_hit)
		else $error("top of segment end not honoured");
	chk_segment_miss: assert property (
		!seg_ok |=> !addr_hit)
		else $error("answered outside programmed segment");

	// Decode refusals outside range and interleave
	chk_below_start: assert property (
		blk < s_q.start |=> !addr_hit)
		else $error("answered below starting address");
	chk_above_end: assert property (
		!s_q.top && blk > s_q.end_addr |=> !addr_hit)
		else $error("answered above ending address");
	chk_ilv_miss: assert property (
		!ilv_ok |=> !addr_hit)
		else $error("answered outside interleave selection");

	// Read-back layout of the remaining registers
	chk_derr_readback: assert property (
		reg_req.rd && reg_req.addr == OFS_DERR_ADDR
		|=> reg_rvalid && reg_rdata[2:0] == 3'h0)
		else $error("error address low bits not zero");
	chk_ref_readback: assert property (
		reg_req.rd && reg_req.addr == OFS_REF_CTL
		|=> reg_rvalid && reg_rdata[31:17] == 15'h0000 && reg_rdata[15:6] == 10'h000)
		else $error("refresh control reserved or force bit not zero");
	chk_end_readback: assert property (
		reg_req.rd && reg_req.addr == OFS_END
		|=> reg_rvalid && reg_rdata[31:17] == 15'h0000 && reg_rdata[5:0] == 6'h00)
		else $error("ending address reserved bits not zero");
	chk_seg_ilv_readback: assert property (
		reg_req.rd && reg_req.addr == OFS_SEG_ILV
		|=> reg_rvalid && reg_rdata[31:21] == 11'h000 && reg_rdata[15:8] == 8'h00
			&& reg_rdata[4:2] == 3'h0)
		else $error("segment and interleave reserved bits not zero");

	// Missed-refresh flag clear and block-state log
	chk_miss_clear: assert property (
		wr_ref && reg_req.wdata[MISS_BIT] && !miss_ev |=> !s_q.miss)
		else $error("missed refresh flag not cleared by write one");
	chk_bs_addr_logged: assert property (
		bs_err.valid |=> bs_held == CAP_UNCORR)
		else $error("block-state error address not logged");
	chk_bs_flags_set: assert property (
		bs_err.valid |=> (s_q.bs_flags & $past(bs_err.kind)) == $past(bs_err.kind))
		else $error("block-state flags not set");

	cov_missed_refresh: cover property (miss_ev);
	cov_address_hit: cover property (addr_hit && s_q.interleave_factor_field == ILV_8WAY);
	cov_force_done: cover property (force_ev ##[1:20] refresh_done);

endmodule

`default_nettype wire
